/* File: hw/hub_product_id_consts.svh */
// Offsets, field positions and reset values of the product identifier registers
`ifndef HUB_PRODUCT_ID_CONSTS_SVH
`define HUB_PRODUCT_ID_CONSTS_SVH
`define PID_OFFS_LOW 8'h03
`define PID_OFFS_HIGH 8'h04
`define PID_USB2_FLIP_MASK 8'h02
`define PID_BYTE_MSB 7
`define PID_BYTE_LSB 0
`define PID_HIGH_MSB 15
`define PID_HIGH_LSB 8
`define PID_ZERO_BYTE 8'h00
`define PID_ZERO_WORD 16'h0000
// Built-in default identifier; the value is arbitrary
`define PID_BUILTIN_DEFAULT 16'h5A3C
`define PID_DEFAULT_LOW 8'h3C
`define PID_DEFAULT_HIGH 8'h5A
`define PID_DEFAULT_USB2 16'h5A3E
`endif

/* File: hw/hub_product_id_pkg.sv */
// Types shared by the product identifier register bank
package hub_product_id_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] ident_t;
   typedef enum logic [1:0] {SRC_BUILTIN, SRC_OTP, SRC_CONFIG} ident_src_e;
   typedef enum {ACC_NONE, ACC_LOW, ACC_HIGH} reg_sel_e;
endpackage : hub_product_id_pkg

/* File: hw/product_ident_sel_if.sv */
// Carrier between the register bank and the identifier source selector
interface product_ident_sel_if;
   import hub_product_id_pkg::*;
   ident_t cfg_pid;
   ident_t cfg_vid;
   logic cfg_written;
   logic otp_valid;
   ident_t otp_pid;
   ident_t eff_pid;
   ident_src_e eff_src;
   modport regs (output cfg_pid, output cfg_vid, output cfg_written, output otp_valid,
                 output otp_pid, input eff_pid, input eff_src);
   modport sel (input cfg_pid, input cfg_vid, input cfg_written, input otp_valid,
                input otp_pid, output eff_pid, output eff_src);
endinterface : product_ident_sel_if

/* File: hw/product_ident_select.sv */
// Priority selection of the effective product identifier
`include "hub_product_id_consts.svh"
module product_ident_select
(
   input wire logic i_mclk,               // Core clock
   input wire logic i_reset_n,            // Asynchronous reset, active low
   product_ident_sel_if.sel sel_bus       // Sources in, effective value out
);
   import hub_product_id_pkg::*;

   logic cfg_use;
   logic otp_use;
   ident_t eff_pid_q;
   ident_src_e eff_src_q;

   // Config values win once either byte was written, unless both identifiers are zero
   assign cfg_use = sel_bus.cfg_written &&
                    ((sel_bus.cfg_pid != `PID_ZERO_WORD) ||
                     (sel_bus.cfg_vid != `PID_ZERO_WORD));
   assign otp_use = sel_bus.otp_valid && (sel_bus.otp_pid != `PID_ZERO_WORD);

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         eff_pid_q <= `PID_BUILTIN_DEFAULT;
         eff_src_q <= SRC_BUILTIN;
      end
      else if (cfg_use)
      begin
         eff_pid_q <= sel_bus.cfg_pid;
         eff_src_q <= SRC_CONFIG;
      end
      else if (otp_use)
      begin
         eff_pid_q <= sel_bus.otp_pid;
         eff_src_q <= SRC_OTP;
      end
      else
      begin
         eff_pid_q <= `PID_BUILTIN_DEFAULT;
         eff_src_q <= SRC_BUILTIN;
      end
   end

   assign sel_bus.eff_pid = eff_pid_q;
   assign sel_bus.eff_src = eff_src_q;
endmodule : product_ident_select

/* File: hw/hub_product_id_regs.sv */
// Product identifier register bank of the hub configuration space
`include "hub_product_id_consts.svh"
module hub_product_id_regs
(
   input wire logic i_mclk,                               // Core clock, 50 MHz
   input wire logic i_reset_n,                            // Asynchronous reset, active low
   input wire logic i_cfg_wr,                             // Config path write strobe
   input wire logic i_cfg_rd,                             // Config path read strobe
   input wire hub_product_id_pkg::byte_t i_cfg_addr,      // Config register offset
   input wire hub_product_id_pkg::byte_t i_cfg_wdata,     // Config write data
   input wire hub_product_id_pkg::ident_t i_cfg_vid,      // Vendor identifier as written
   input wire logic i_otp_valid,                          // One-time memory contents loaded
   input wire hub_product_id_pkg::ident_t i_otp_pid,      // Product identifier from one-time memory
   output logic o_cfg_ack,                                // Access taken for this block
   output hub_product_id_pkg::byte_t o_cfg_rdata,         // Read data, registered
   output logic o_cfg_rvalid,                             // Read data valid, one cycle
   output hub_product_id_pkg::ident_t o_pid_superspeed,   // SuperSpeed descriptor identifier
   output hub_product_id_pkg::ident_t o_pid_usb2,         // USB 2.0 descriptor identifier
   output hub_product_id_pkg::ident_src_e o_pid_source    // Source of the effective value
);
   import hub_product_id_pkg::*;

   function automatic reg_sel_e decode_offset(input byte_t addr);
      reg_sel_e sel;
      sel = ACC_NONE;
      if (addr == `PID_OFFS_LOW)
      begin
         sel = ACC_LOW;
      end
      else if (addr == `PID_OFFS_HIGH)
      begin
         sel = ACC_HIGH;
      end
      return sel;
   endfunction : decode_offset

   // USB 2.0 low byte differs from the effective low byte in a single bit
   function automatic byte_t usb2_low_byte(input byte_t low);
      return low ^ `PID_USB2_FLIP_MASK;
   endfunction : usb2_low_byte

   // Carrier to the source selector
   product_ident_sel_if sel_bus ();

   // Decoded strobes, stored bytes and registered outputs
   reg_sel_e wr_sel;
   reg_sel_e rd_sel;
   byte_t low_q;
   byte_t high_q;
   logic low_written_q;
   logic high_written_q;
   byte_t eff_low;
   byte_t eff_high;
   byte_t rdata_q;
   logic rvalid_q;
   ident_t ss_q;
   ident_t usb2_q;
   ident_src_e src_q;

   // Decoded strobes and the ack only count at the two offsets of this block
   assign wr_sel = i_cfg_wr ? decode_offset(i_cfg_addr) : ACC_NONE;
   assign rd_sel = i_cfg_rd ? decode_offset(i_cfg_addr) : ACC_NONE;
   assign o_cfg_ack = (wr_sel != ACC_NONE) || (rd_sel != ACC_NONE);

   // Stored low byte, written by the configuration path
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         low_q <= `PID_DEFAULT_LOW;
      end
      else if (wr_sel == ACC_LOW)
      begin
         low_q <= i_cfg_wdata;
      end
   end

   // Stored high byte, written by the configuration path
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         high_q <= `PID_DEFAULT_HIGH;
      end
      else if (wr_sel == ACC_HIGH)
      begin
         high_q <= i_cfg_wdata;
      end
   end

   // Each flag remembers that the configuration path supplied that byte
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         low_written_q <= 1'b0;
      end
      else if (wr_sel == ACC_LOW)
      begin
         low_written_q <= 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         high_written_q <= 1'b0;
      end
      else if (wr_sel == ACC_HIGH)
      begin
         high_written_q <= 1'b1;
      end
   end

   assign sel_bus.cfg_pid = {high_q, low_q};
   assign sel_bus.cfg_vid = i_cfg_vid;
   // A write to either byte hands the choice to the configuration values unless both identifiers are zero
   assign sel_bus.cfg_written = low_written_q || high_written_q;
   assign sel_bus.otp_valid = i_otp_valid;
   assign sel_bus.otp_pid = i_otp_pid;

   // Picks the configuration, one-time memory or built-in value
   product_ident_select u_select
   (
      .i_mclk (i_mclk),
      .i_reset_n (i_reset_n),
      .sel_bus (sel_bus.sel)
   );

   // Bytes of the identifier actually in use
   assign eff_low = sel_bus.eff_pid[`PID_BYTE_MSB:`PID_BYTE_LSB];
   assign eff_high = sel_bus.eff_pid[`PID_HIGH_MSB:`PID_HIGH_LSB];

   // Read data show the identifier in use, or zero after a read at another offset, and hold until the next read
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rdata_q <= `PID_ZERO_BYTE;
      end
      else if (rd_sel == ACC_LOW)
      begin
         rdata_q <= eff_low;
      end
      else if (rd_sel == ACC_HIGH)
      begin
         rdata_q <= eff_high;
      end
      else if (i_cfg_rd)
      begin
         rdata_q <= `PID_ZERO_BYTE;
      end
   end

   // Read valid follows every read strobe, mapped or not
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= i_cfg_rd;
      end
   end

   // SuperSpeed descriptor identifier
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         ss_q <= `PID_BUILTIN_DEFAULT;
      end
      else
      begin
         ss_q <= sel_bus.eff_pid;
      end
   end

   // USB 2.0 descriptor identifier
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         usb2_q <= `PID_DEFAULT_USB2;
      end
      else
      begin
         usb2_q <= {eff_high, usb2_low_byte(eff_low)};
      end
   end

   // Source of the identifier in use
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         src_q <= SRC_BUILTIN;
      end
      else
      begin
         src_q <= sel_bus.eff_src;
      end
   end

   // Outputs come straight from the flip-flops above
   assign o_cfg_rdata = rdata_q;
   assign o_cfg_rvalid = rvalid_q;
   assign o_pid_superspeed = ss_q;
   assign o_pid_usb2 = usb2_q;
   assign o_pid_source = src_q;
endmodule : hub_product_id_regs

/* File: test/hub_product_id_regs_checker.sv */
// Checker for the product identifier register bank
`include "hub_product_id_consts.svh"
module hub_product_id_regs_checker
   import hub_product_id_pkg::*;
(
   input wire logic i_mclk,              // Core clock
   input wire logic i_reset_n,           // Reset, active low
   input wire logic i_cfg_wr,            // Write strobe
   input wire logic i_cfg_rd,            // Read strobe
   input wire logic i_otp_valid,         // One-time memory loaded
   input wire logic o_cfg_ack,           // Access taken
   input wire logic o_cfg_rvalid,        // Read data valid
   input wire byte_t i_cfg_addr,         // Register offset
   input wire byte_t i_cfg_wdata,        // Write data
   input wire byte_t o_cfg_rdata,        // Read data
   input wire ident_t i_cfg_vid,         // Vendor identifier
   input wire ident_t i_otp_pid,         // One-time memory identifier
   input wire ident_t o_pid_superspeed,  // SuperSpeed identifier
   input wire ident_t o_pid_usb2,        // USB 2.0 identifier
   input wire ident_src_e o_pid_source   // Source in use
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   a_usb2_flip: assert property (o_pid_usb2 == (o_pid_superspeed ^ 16'h0002))
      else $error("usb2 identifier not flipped");
   a_low_ack: assert property (i_cfg_rd && i_cfg_addr == 8'h03 |-> o_cfg_ack)
      else $error("no ack at low byte");
   a_high_ack: assert property (i_cfg_wr && i_cfg_addr == 8'h04 |-> o_cfg_ack)
      else $error("no ack at high byte");
   a_low_read: assert property (i_cfg_rd && i_cfg_addr == 8'h03 |=> o_cfg_rvalid &&
      {8'h00, o_cfg_rdata} == (o_pid_superspeed & 16'h00FF)) else $error("bad low read");
   a_high_read: assert property (i_cfg_rd && i_cfg_addr == 8'h04 |=>
      {o_cfg_rdata, 8'h00} == (o_pid_superspeed & 16'hFF00)) else $error("bad high read");
   a_cfg_used: assert property (i_cfg_wr && i_cfg_addr == 8'h03 && i_cfg_wdata != 8'h00
      |-> ##3 o_pid_source == SRC_CONFIG) else $error("written value not used");
   a_cfg_high: assert property (i_cfg_wr && i_cfg_addr == 8'h04 && i_cfg_wdata != 8'h00
      |-> ##3 o_pid_superspeed[15:8] == $past(i_cfg_wdata, 3)) else $error("high byte lost");
   a_otp_used: assert property (o_pid_source == SRC_OTP |->
      o_pid_superspeed == $past(i_otp_pid, 2)) else $error("otp value not used");
   a_builtin_used: assert property (o_pid_source == SRC_BUILTIN |->
      o_pid_superspeed == `PID_BUILTIN_DEFAULT) else $error("builtin value not used");
   c_otp: cover property (o_pid_source == SRC_OTP);
   c_cfg: cover property (o_pid_source == SRC_CONFIG);
   c_read: cover property (i_cfg_rd ##1 o_cfg_rvalid);
endmodule : hub_product_id_regs_checker
bind hub_product_id_regs hub_product_id_regs_checker chk (.i_mclk(i_mclk),
   .i_reset_n(i_reset_n), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_otp_valid(i_otp_valid),
   .o_cfg_ack(o_cfg_ack), .o_cfg_rvalid(o_cfg_rvalid), .i_cfg_addr(i_cfg_addr),
   .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_cfg_vid(i_cfg_vid),
   .i_otp_pid(i_otp_pid), .o_pid_superspeed(o_pid_superspeed), .o_pid_usb2(o_pid_usb2),
   .o_pid_source(o_pid_source));

/* File: test/cfg_loader_model.sv */
// Configuration loader model driving the register strobes
module cfg_loader_model
   import hub_product_id_pkg::*;
(
   input wire logic i_mclk,  // Core clock
   input wire logic i_ack,   // Access taken
   output logic o_wr,        // Write strobe
   output logic o_rd,        // Read strobe
   output byte_t o_addr,     // Register offset
   output byte_t o_wdata     // Write data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
   task automatic access(input logic wr, input byte_t addr, data, output logic ack);
      @(posedge i_mclk);
      #1 {o_wr, o_rd, o_addr, o_wdata} = {wr, !wr, addr, data};
      @(posedge i_mclk);
      ack = i_ack;
      // Released lines show the inverse, not the last value
      #1 {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~addr, ~data};
   endtask : access
endmodule : cfg_loader_model

/* File: test/hub_product_id_regs_bench.sv */
// Bench for the product identifier register bank
`include "hub_product_id_consts.svh"
module hub_product_id_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import hub_product_id_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, otp_ok = 1'b0, wr, rd, ack, rvalid, got;
   byte_t addr, wdata, rdata;
   ident_t vendor_identifier = 16'h1111, otp = 16'h0000, ss, u2;
   ident_src_e src;
   int n_mismatch = 0, n_tests = 0;
   always #10 clk = ~clk;
   hub_product_id_regs DUT (.i_mclk(clk), .i_reset_n(rst_n), .i_cfg_wr(wr), .i_cfg_rd(rd),
      .i_cfg_addr(addr), .i_cfg_wdata(wdata), .i_cfg_vid(vendor_identifier), .i_otp_valid(otp_ok),
      .i_otp_pid(otp), .o_cfg_ack(ack), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
      .o_pid_superspeed(ss), .o_pid_usb2(u2), .o_pid_source(src));
   cfg_loader_model host (.i_mclk(clk), .i_ack(ack), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wdata));
   task automatic check(input string what, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task automatic otp_source();
      check("ss", ss, `PID_BUILTIN_DEFAULT);
      {otp, otp_ok} = {16'h1234, 1'b1};
      settle();
      check("ss", ss, 16'h1234);
      check("src", src, SRC_OTP);
   endtask : otp_source
   task automatic config_write();
      host.access(1'b1, 8'h03, 8'hA5, got);
      check("ack3", got, 1'b1);
      host.access(1'b1, 8'h04, 8'h7E, got);
      check("ack4", got, 1'b1);
      settle();
      check("ss", ss, 16'h7EA5);
      check("usb2", u2, 16'h7EA7);
      host.access(1'b0, 8'h03, 8'h00, got);
      check("rd3", rdata, 8'hA5);
      host.access(1'b0, 8'h04, 8'h00, got);
      check("rd4", {got, rdata}, 9'h17E);
      host.access(1'b0, 8'h05, 8'h00, got);
      check("rd5", {got, rvalid, rdata}, 10'h100);
   endtask : config_write
   task automatic zero_fallback();
      vendor_identifier = 16'h0000;
      host.access(1'b1, 8'h03, 8'h00, got);
      host.access(1'b1, 8'h04, 8'h00, got);
      settle();
      check("ss", ss, 16'h1234);
      otp = 16'h0000;
      settle();
      check("src", src, SRC_BUILTIN);
   endtask : zero_fallback
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      otp_source();
      config_write();
      zero_fallback();
      wrap_up();
   end
   initial
   begin
      #20000;
      n_mismatch++;
      wrap_up();
   end
endmodule : hub_product_id_regs_bench
